// ---- hdl/uii_char_timer.sv ----
// Character timeout timer for the receive FIFO.
// Assumes one tick pulse per character time from the baud logic.
`timescale 1ns/1ps
module uii_char_timer (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   // Receive FIFO view
   input  wire logic i_fifo_mode,
   input  wire logic i_nonempty,
   input  wire logic i_activity,
   input  wire logic i_char_tick,
   // Result
   output logic      o_expired
);

   logic [2:0] cnt_q;

   // Saturates so that one idle stretch gives one expiry pulse only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= 3'h0;
      end else if (i_ce) begin
         if (!i_fifo_mode || !i_nonempty || i_activity) begin
            cnt_q <= 3'h0;
         end else if (i_char_tick && cnt_q != uii_pkg::TO_CHARS) begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   assign o_expired = i_fifo_mode && i_nonempty && !i_activity && i_char_tick &&
                      (cnt_q == uii_pkg::TO_CHARS - 3'h1);

endmodule // uii_char_timer

// ---- hdl/uii_pkg.sv ----
// Package for the serial port interrupt identification block.
// Assumes an 8-bit host I/O bus with a 3-bit offset inside the port.
package uii_pkg;

   // ****************************************
   // Register offsets (DLAB=0 where relevant)
   // ****************************************
   localparam logic [2:0] OFS_DATA = 3'h0;   // Receive buffer / transmit holding
   localparam logic [2:0] OFS_INT_EN = 3'h1;
   localparam logic [2:0] OFS_ID   = 3'h2;   // Read: identification, write: FIFO control
   localparam logic [2:0] OFS_LSR  = 3'h5;
   localparam logic [2:0] OFS_MSR  = 3'h6;

   // ****************************************
   // Field positions and values
   // ****************************************
   localparam int         INT_EN_RX_BIT   = 0;
   localparam int         INT_EN_THRE_BIT = 1;
   localparam int         INT_EN_LS_BIT   = 2;
   localparam int         INT_EN_MS_BIT   = 3;
   localparam int         FIFO_CTL_EN_BIT = 0;
   localparam logic [7:0] ID_RESET        = 8'h01;
   localparam logic [7:0] INT_EN_RESET    = 8'h00;
   localparam logic [3:0] CODE_NONE    = 4'h1;
   localparam logic [3:0] CODE_LS      = 4'h6;
   localparam logic [3:0] CODE_RX      = 4'h4;
   localparam logic [3:0] CODE_TO      = 4'hC;
   localparam logic [3:0] CODE_THRE    = 4'h2;
   localparam logic [3:0] CODE_MS      = 4'h0;
   localparam logic [1:0] FIFO_ON      = 2'h3;
   localparam logic [1:0] FIFO_OFF     = 2'h0;

   // ****************************************
   // Counts
   // ****************************************
   localparam logic [2:0] TO_CHARS     = 3'h4;   // Idle character times before timeout

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b01,
      ACC_HELD = 2'b10
   } uii_acc_type;

   typedef struct packed {
      logic ls;
      logic rx;
      logic to;
      logic thre;
      logic ms;
   } uii_src_type;

endpackage

// ---- hdl/uii_top.sv ----
// Interrupt prioritisation and identification for one serial port.
// Assumes condition pulses and levels from the serial core, synchronous to I_MCLK,
// and a host bus whose read strobe stays high for the whole access.
`timescale 1ns/1ps

// Notes on behaviour
// - Identification register at offset 2, resets 01
// - Priority: line status, rx data, THRE, modem
// - Read start freezes the reported value
// - Conditions still recorded while value frozen
// - Bits 7:6 are 11 or 00 only
// - Bit 3 zero outside FIFO mode
// - Timeout after four idle character times
// - Timeout code 1100, ranked just below rx data
// - Bit 0 low when pending, else 0001
// - Line errors code 11, cleared by LSR read
// - Rx data code 10, cleared reading buffer
// - Timeout cleared by reading receive buffer
// - THRE code 01, cleared by write or read
// - Modem change code 00, cleared MSR read
// - Disabled conditions neither shown nor requested
// - Rx data enable also gates timeout
// - FIFO mode follows FIFO control bit 0
module uii_top (
   // Clock, reset, enable
   input  wire logic       I_MCLK,
   input  wire logic       I_RST,
   input  wire logic       I_CE,
   // Host I/O bus
   input  wire logic [2:0] I_ADDR,
   input  wire logic       I_RD,
   input  wire logic       I_WR,
   input  wire logic       I_DLAB,
   input  wire logic [7:0] I_WDATA,
   output logic      [7:0] O_ID_DATA,
   output logic      [7:0] O_INT_EN,
   output logic            O_FIFO_MODE,
   // Serial core conditions
   input  wire logic       I_LINE_ERR,
   input  wire logic       I_RX_AVAIL,
   input  wire logic       I_THRE_SET,
   input  wire logic       I_MODEM_CHG,
   input  wire logic       I_RX_NONEMPTY,
   input  wire logic       I_RX_ACTIVITY,
   input  wire logic       I_CHAR_TICK,
   // Interrupt request
   output logic            O_IRQ
);

   // ****************************************
   // Bus decode
   // ****************************************
   logic rd_ident;
   logic rd_rbr;
   logic wr_thr;
   logic rd_lsr;
   logic rd_msr;
   logic wr_int_en;
   logic wr_fifo_ctl;
   logic ident_done;

   assign rd_ident    = I_RD && I_ADDR == uii_pkg::OFS_ID;
   assign rd_rbr      = I_RD && !I_DLAB && I_ADDR == uii_pkg::OFS_DATA;
   assign wr_thr      = I_WR && !I_DLAB && I_ADDR == uii_pkg::OFS_DATA;
   assign rd_lsr      = I_RD && I_ADDR == uii_pkg::OFS_LSR;
   assign rd_msr      = I_RD && I_ADDR == uii_pkg::OFS_MSR;
   assign wr_int_en   = I_WR && !I_DLAB && I_ADDR == uii_pkg::OFS_INT_EN;
   assign wr_fifo_ctl = I_WR && I_ADDR == uii_pkg::OFS_ID;

   // ****************************************
   // Control registers
   // ****************************************
   logic [3:0] int_en_q;
   logic       fifo_q;

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         int_en_q <= uii_pkg::INT_EN_RESET[3:0];
      end else if (I_CE && wr_int_en) begin
         int_en_q <= I_WDATA[3:0];
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         fifo_q <= 1'b0;
      end else if (I_CE && wr_fifo_ctl) begin
         fifo_q <= I_WDATA[uii_pkg::FIFO_CTL_EN_BIT];
      end
   end

   assign O_INT_EN    = {4'h0, int_en_q};
   assign O_FIFO_MODE = fifo_q;

   // ****************************************
   // Access tracking
   // ****************************************
   uii_pkg::uii_acc_type acc_q;
   logic                 access_q;

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         acc_q <= uii_pkg::ACC_IDLE;
      end else if (I_CE) begin
         case (acc_q)
            uii_pkg::ACC_IDLE: begin
               if (rd_ident) begin
                  acc_q <= uii_pkg::ACC_HELD;
               end
            end
            uii_pkg::ACC_HELD: begin
               if (!rd_ident) begin
                  acc_q <= uii_pkg::ACC_IDLE;
               end
            end
            default: begin
               acc_q <= uii_pkg::ACC_IDLE;
            end
         endcase
      end
   end

   assign access_q = acc_q == uii_pkg::ACC_HELD;
   assign ident_done = access_q && !rd_ident;

   // ****************************************
   // Condition flags
   // ****************************************
   logic ls_q;
   logic to_q;
   logic thre_q;
   logic ms_q;
   logic to_expired;

   uii_char_timer u_timer (
      .i_clk       (I_MCLK),
      .i_rst       (I_RST),
      .i_ce        (I_CE),
      .i_fifo_mode (fifo_q),
      .i_nonempty  (I_RX_NONEMPTY),
      .i_activity  (I_RX_ACTIVITY),
      .i_char_tick (I_CHAR_TICK),
      .o_expired   (to_expired)
   );

   // Flags keep recording during a held read; set beats clear in the same cycle
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         ls_q <= 1'b0;
      end else if (I_CE) begin
         if (I_LINE_ERR) begin
            ls_q <= 1'b1;
         end else if (rd_lsr) begin
            ls_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         to_q <= 1'b0;
      end else if (I_CE) begin
         if (!fifo_q) begin
            to_q <= 1'b0;
         end else if (to_expired) begin
            to_q <= 1'b1;
         end else if (rd_rbr) begin
            to_q <= 1'b0;
         end
      end
   end

   // Cleared by a transmit holding write, or at the end of the read that actually showed it
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         thre_q <= 1'b0;
      end else if (I_CE) begin
         if (I_THRE_SET) begin
            thre_q <= 1'b1;
         end else if (wr_thr || (ident_done && O_ID_DATA[3:0] == uii_pkg::CODE_THRE)) begin
            thre_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         ms_q <= 1'b0;
      end else if (I_CE) begin
         if (I_MODEM_CHG) begin
            ms_q <= 1'b1;
         end else if (rd_msr) begin
            ms_q <= 1'b0;
         end
      end
   end

   // Rx data is a live level from the core; its clear is the buffer read there
   uii_pkg::uii_src_type pend;

   always_comb begin
      pend.ls   = ls_q && int_en_q[uii_pkg::INT_EN_LS_BIT];
      pend.rx   = I_RX_AVAIL && int_en_q[uii_pkg::INT_EN_RX_BIT];
      pend.to   = to_q && fifo_q && int_en_q[uii_pkg::INT_EN_RX_BIT];
      pend.thre = thre_q && int_en_q[uii_pkg::INT_EN_THRE_BIT];
      pend.ms   = ms_q && int_en_q[uii_pkg::INT_EN_MS_BIT];
   end

   assign O_IRQ = |pend;

   // ****************************************
   // Identification value
   // ****************************************
   logic [3:0] code_d;
   logic [7:0] id_d;
   logic [7:0] id_q;

   always_comb begin
      if (pend.ls) begin
         code_d = uii_pkg::CODE_LS;
      end else if (pend.rx) begin
         code_d = uii_pkg::CODE_RX;
      end else if (pend.to) begin
         code_d = uii_pkg::CODE_TO;
      end else if (pend.thre) begin
         code_d = uii_pkg::CODE_THRE;
      end else if (pend.ms) begin
         code_d = uii_pkg::CODE_MS;
      end else begin
         code_d = uii_pkg::CODE_NONE;
      end
      id_d = {fifo_q ? uii_pkg::FIFO_ON : uii_pkg::FIFO_OFF, 2'h0, code_d};
   end

   // Snapshot taken at the edge the read is first seen, then held to its end
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         id_q <= uii_pkg::ID_RESET;
      end else if (I_CE && !access_q) begin
         id_q <= id_d;
      end
   end

   assign O_ID_DATA = id_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST || !I_CE);

   sequence s_thre_shown_done;
      ident_done && id_q[3:0] == uii_pkg::CODE_THRE && !I_THRE_SET;
   endsequence

   chk_reset_value: assert property (disable iff (1'b0) $past(I_RST) |-> O_ID_DATA == 8'h01)
      else $error("identification value wrong after reset");
   chk_fifo_bits: assert property (O_ID_DATA[7:6] == 2'b00 || O_ID_DATA[7:6] == 2'b11)
      else $error("fifo status bits illegal");
   chk_bit3_nonfifo: assert property (O_ID_DATA[7:6] == 2'b00 |-> !O_ID_DATA[3])
      else $error("timeout bit set outside fifo mode");
   chk_none_code: assert property (O_ID_DATA[0] |-> O_ID_DATA[5:1] == 5'h00)
      else $error("no-interrupt code malformed");
   chk_freeze_hold: assert property (access_q && rd_ident |=> $stable(O_ID_DATA))
      else $error("identification changed during read");
   chk_lsr_top: assert property (pend.ls && !access_q |=> O_ID_DATA[3:0] == 4'h6)
      else $error("line status not reported first");
   chk_irq_gate: assert property (int_en_q == 4'h0 |-> !O_IRQ)
      else $error("irq raised with all enables clear");
   chk_thre_clear: assert property (s_thre_shown_done |=> !thre_q)
      else $error("thre not cleared by identification read");
   chk_timeout_set: assert property (to_expired && fifo_q |=> to_q)
      else $error("timeout not flagged");
   chk_rbr_clear: assert property (rd_rbr && !to_expired && fifo_q |=> !to_q)
      else $error("timeout not cleared by buffer read");

endmodule // uii_top

// ---- tb/uart_interrupt_identification_bench.sv ----
// Self-checking bench for the interrupt identification block.
// Assumes the host model and the design sources.
`timescale 1ns/1ps
module uart_interrupt_identification_bench;
   typedef struct packed {
      logic [7:0] ie;
      logic       fifo;
      logic [3:0] src;
      logic [7:0] id;
   } uii_row_type;
   logic        clk;
   logic        rst;
   logic        lerr;
   logic        rxav;
   logic        thre;
   logic        mchg;
   logic        nemp;
   logic        tick;
   logic        act;
   logic [2:0]  addr;
   logic        rd;
   logic        wr;
   logic [7:0]  wdata;
   logic [7:0]  id;
   logic [7:0]  int_en;
   logic        fmode;
   logic        irq;
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   uii_row_type rows [8] = '{'{8'h0F, 1'b0, 4'hF, 8'h06}, '{8'h0F, 1'b0, 4'h7, 8'h04},
      '{8'h0F, 1'b1, 4'h3, 8'hC2}, '{8'h0F, 1'b0, 4'h1, 8'h00}, '{8'h0B, 1'b1, 4'h8, 8'hC1},
      '{8'h0D, 1'b0, 4'h2, 8'h01}, '{8'h0F, 1'b1, 4'h4, 8'hC4}, '{8'h00, 1'b0, 4'hF, 8'h01}};
   uii_top uii_top_inst (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1), .I_ADDR(addr), .I_RD(rd),
      .I_WR(wr), .I_DLAB(1'b0), .I_WDATA(wdata), .O_ID_DATA(id), .O_INT_EN(int_en), .O_FIFO_MODE(fmode),
      .I_LINE_ERR(lerr), .I_RX_AVAIL(rxav), .I_THRE_SET(thre), .I_MODEM_CHG(mchg),
      .I_RX_NONEMPTY(nemp), .I_RX_ACTIVITY(act), .I_CHAR_TICK(tick), .O_IRQ(irq));
   uii_host uii_host_inst (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
   // ****
   // Helpers
   // ****
   task automatic stop_test();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Rx data is a level, so it stays up until the clear step
   task automatic pulse(input logic [3:0] s);
      @(negedge clk);
      {lerr, rxav, thre, mchg} = s;
      @(negedge clk);
      {lerr, thre, mchg} = 3'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
      end
      @(negedge clk);
   endtask
   task automatic rd1(input logic [2:0] a);
      uii_host_inst.rd_begin(a);
      uii_host_inst.rd_end();
      @(negedge clk);
   endtask
   task automatic wr1(input logic [2:0] a, input logic [7:0] d);
      uii_host_inst.wr(a, d);
      @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      {rst, lerr, rxav, thre, mchg, nemp, tick, act} = 8'h80;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      cmp(id, 8'h01);
      cmp(int_en, 8'h00);
      cmp1(fmode, 1'b0);
      cmp1(irq, 1'b0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr1(3'h1, rows[i].ie);
         wr1(3'h2, {7'h00, rows[i].fifo});
         pulse(rows[i].src);
         cmp(id, rows[i].id);
         cmp1(irq, ~rows[i].id[0]);
         cmp1(fmode, rows[i].fifo);
         rxav = 1'b0;
         rd1(3'h5);
         rd1(3'h6);
         wr1(3'h0, 8'h00);
         cmp(id, {{2{rows[i].fifo}}, 6'h01});
      end
      $display("test table done");
      wr1(3'h1, 8'h0F);
      wr1(3'h2, 8'h00);
      pulse(4'h2);
      uii_host_inst.rd_begin(3'h2);
      @(negedge clk);
      pulse(4'h8);
      cmp(id, 8'h02);
      uii_host_inst.rd_end();
      // The snapshot reloads at the second edge after the read strobe has dropped
      repeat (2) @(negedge clk);
      cmp(id, 8'h06);
      rd1(3'h5);
      cmp(id, 8'h01);
      $display("test freeze done");
      wr1(3'h1, 8'h01);
      nemp = 1'b1;
      ticks(4);
      cmp(id, 8'h01);
      nemp = 1'b0;
      wr1(3'h2, 8'h01);
      nemp = 1'b1;
      ticks(3);
      cmp(id, 8'hC1);
      ticks(1);
      cmp(id, 8'hCC);
      cmp1(irq, 1'b1);
      wr1(3'h1, 8'h00);
      cmp(id, 8'hC1);
      cmp1(irq, 1'b0);
      wr1(3'h1, 8'h01);
      cmp(id, 8'hCC);
      rd1(3'h0);
      cmp(id, 8'hC1);
      $display("test timeout done");
      // Activity restarts the idle count, so three more ticks must not expire
      act = 1'b1;
      @(negedge clk);
      act = 1'b0;
      ticks(3);
      act = 1'b1;
      @(negedge clk);
      act = 1'b0;
      ticks(3);
      cmp(id, 8'hC1);
      ticks(1);
      cmp(id, 8'hCC);
      $display("test activity done");
      nemp = 1'b0;
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      cmp(id, 8'h01);
      cmp(int_en, 8'h00);
      cmp1(fmode, 1'b0);
      cmp1(irq, 1'b0);
      $display("test mid reset done");
      stop_test();
   end
endmodule // uart_interrupt_identification_bench

// ---- tb/uii_host.sv ----
// Host model driving the port register bus.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
module uii_host (
   // Clock
   input  wire logic       i_clk,
   // Bus
   output logic      [2:0] o_addr,
   output logic            o_rd,
   output logic            o_wr,
   output logic      [7:0] o_wdata
);
   // ****
   // Bus cycles
   // ****
   initial begin
      o_addr  = 3'h7;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic rd_begin(input logic [2:0] a);
      @(negedge i_clk);
      o_addr = a;
      o_rd   = 1'b1;
   endtask
   // Idles on an unmapped offset so no stale decode lingers
   task automatic rd_end();
      @(negedge i_clk);
      o_rd   = 1'b0;
      o_addr = 3'h7;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clk);
      o_wr    = 1'b0;
      o_addr  = 3'h7;
      o_wdata = ~d;
   endtask
endmodule // uii_host
